// ==== logic/lpm_params.svh ====
// Constants for the low-power mode controller
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH
`define LPM_CLK_NS 10
`define LPM_WAKE_NS 8000
`define LPM_WAKE_CYC (`LPM_WAKE_NS / `LPM_CLK_NS)
`define LPM_WAKE_CNT_W 10
`define LPM_RANGE1 2'h1
`define LPM_RANGE2 2'h2
`define LPM_RANGE3 2'h3
`define LPM_RANGE_RST 2'h2
`define LPM_R1_MAX_KHZ 16'h7D00
`define LPM_R2_MAX_KHZ 16'h3E80
`define LPM_R3_MAX_KHZ 16'h0FA0
`define LPM_MS_MIN_KHZ 16'h0083
`define LPM_SRC_MS_OSC 2'h0
`define LPM_SRC_FAST_INT 2'h1
`define LPM_SRC_FAST_XTAL 2'h2
`define LPM_SRC_PLL 2'h3
`define LPM_SRC_RST 2'h0
`define LPM_BROWNOUT_LVL_RST 3'h1
`define LPM_EXT_LINES 16
`define LPM_WAKE_W 25
`endif

// ==== logic/lpm_pkg.sv ====
// Types shared by the low-power mode controller
`default_nettype none
package lpm_pkg;
  typedef enum logic [3:0] {
    BOOT_WAIT,
    BOOT_LOAD,
    RUN,
    LP_RUN,
    SLEEP,
    LP_SLEEP,
    STOP,
    WAKE
  } lpm_state_e;
  typedef logic [1:0] lpm_range_t;
  typedef logic [1:0] lpm_src_t;
endpackage
`default_nettype wire

// ==== logic/lpm_wake_merge.sv ====
// Merges stop-mode wake lines and records which ones fired
`timescale 1ns/1ps
`default_nettype none
module lpm_wake_merge #(
  parameter int W = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_watch,
  input wire logic [W-1:0] i_lines,
  output logic o_hit,
  output logic [W-1:0] o_src
);
  // Level sensitive so a line already high at stop entry still wakes
  assign o_hit = i_watch && (|i_lines);

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_src <= '0;
    end
    else if (o_hit)
    begin
      o_src <= i_lines;
    end
  end
endmodule
`default_nettype wire

// ==== logic/lpm_ctrl.sv ====
// Low-power mode sequencer: ranges, sleep, low-power run/sleep, stop, boot
`timescale 1ns/1ps
`default_nettype none
`include "lpm_params.svh"
module lpm_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_supply_ok,
  input wire logic i_brownout_strap,
  input wire logic i_opt_valid,
  input wire logic [2:0] i_opt_brownout_lvl,
  input wire logic i_opt_brownout_off,
  input wire logic i_range_wr,
  input wire logic [1:0] i_range_sel,
  input wire logic i_src_wr,
  input wire logic [1:0] i_src_sel,
  input wire logic i_lprun_req,
  input wire logic i_lp_req,
  input wire logic i_deep,
  input wire logic i_core_halted,
  input wire logic i_irq_any,
  input wire logic i_event,
  input wire logic [`LPM_EXT_LINES-1:0] i_ext_lines,
  input wire logic i_supply_det,
  input wire logic i_cmp1,
  input wire logic i_cmp2,
  input wire logic i_vref_on,
  input wire logic [1:0] i_rtc_alarm,
  input wire logic i_usb_wake,
  input wire logic i_rtc_tamper,
  input wire logic i_rtc_tstamp,
  input wire logic i_rtc_wake,
  output logic o_opt_load_start,
  output logic o_boot_done,
  output logic o_por_thr_high,
  output logic o_brownout_en,
  output logic [2:0] o_brownout_lvl,
  output logic o_vdd_min_low,
  output logic [1:0] o_vrange,
  output logic [1:0] o_clk_src,
  output logic [15:0] o_fmax_khz,
  output logic o_cfg_refused,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_pll_en,
  output logic o_ms_osc_en,
  output logic o_ms_osc_min,
  output logic o_fast_int_en,
  output logic o_fast_xtal_en,
  output logic o_slow_osc_en,
  output logic o_reg_lp,
  output logic o_retain,
  output logic o_wake_pulse,
  output logic [`LPM_WAKE_W-1:0] o_wake_src,
  output logic [3:0] o_mode
);
  localparam int WAKE_MAX = `LPM_WAKE_CYC;

  lpm_pkg::lpm_state_e state_q, state_d;
  logic [`LPM_WAKE_CNT_W-1:0] wcnt_q;
  logic wake_any, stop_hit, wcnt_done, range_ok, src_ok;
  logic [`LPM_WAKE_W-1:0] wake_lines;

  assign wake_any = i_irq_any || i_event;
  // Comparator events only count while the internal reference is on
  assign wake_lines = {i_ext_lines, i_supply_det, i_cmp1 && i_vref_on, i_cmp2 && i_vref_on,
                       i_rtc_alarm, i_usb_wake, i_rtc_tamper, i_rtc_tstamp, i_rtc_wake};
  assign wcnt_done = (wcnt_q == `LPM_WAKE_CNT_W'(`LPM_WAKE_CYC - 2));

  lpm_wake_merge #(.W(`LPM_WAKE_W)) u_wake (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_watch(state_q == lpm_pkg::STOP),
    .i_lines(wake_lines),
    .o_hit(stop_hit),
    .o_src(o_wake_src)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      lpm_pkg::BOOT_WAIT: if (i_supply_ok) state_d = lpm_pkg::BOOT_LOAD;
      lpm_pkg::BOOT_LOAD: if (i_opt_valid) state_d = lpm_pkg::RUN;
      lpm_pkg::RUN:
      begin
        // Sleep and stop entry waits for the core to report it has halted
        if (i_lp_req && i_core_halted)
          state_d = i_deep ? lpm_pkg::STOP : lpm_pkg::SLEEP;
        else if (i_lprun_req && o_clk_src == `LPM_SRC_MS_OSC)
          state_d = lpm_pkg::LP_RUN;
      end
      lpm_pkg::LP_RUN:
      begin
        if (i_lp_req && i_core_halted)
          state_d = i_deep ? lpm_pkg::STOP : lpm_pkg::LP_SLEEP;
        else if (!i_lprun_req)
          state_d = lpm_pkg::RUN;
      end
      lpm_pkg::SLEEP: if (wake_any) state_d = lpm_pkg::RUN;
      lpm_pkg::LP_SLEEP: if (wake_any) state_d = lpm_pkg::RUN;
      lpm_pkg::STOP: if (stop_hit) state_d = lpm_pkg::WAKE;
      lpm_pkg::WAKE: if (wcnt_done) state_d = lpm_pkg::RUN;
      default: state_d = lpm_pkg::BOOT_WAIT;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_q <= lpm_pkg::BOOT_WAIT;
    else
      state_q <= state_d;
  end

  // Oscillator restart budget; the count is sized so stop exit stays inside the bound
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      wcnt_q <= '0;
    else if (state_q == lpm_pkg::WAKE)
      wcnt_q <= wcnt_q + 1'b1;
    else
      wcnt_q <= '0;
  end

  // Clock and regulator controls are registered from the next state
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_cpu_clk_en <= 1'b0;
      o_periph_clk_en <= 1'b0;
      o_ms_osc_en <= 1'b1;
      o_ms_osc_min <= 1'b0;
      o_pll_en <= 1'b0;
      o_fast_int_en <= 1'b0;
      o_fast_xtal_en <= 1'b0;
      o_slow_osc_en <= 1'b1;
      o_reg_lp <= 1'b0;
      o_retain <= 1'b0;
      o_mode <= 4'h0;
    end
    else
    begin
      o_cpu_clk_en <= state_d == lpm_pkg::RUN || state_d == lpm_pkg::LP_RUN;
      o_periph_clk_en <= state_d != lpm_pkg::STOP && state_d != lpm_pkg::WAKE;
      o_ms_osc_en <= state_d != lpm_pkg::STOP;
      o_ms_osc_min <= state_d == lpm_pkg::LP_RUN || state_d == lpm_pkg::LP_SLEEP;
      o_pll_en <= state_d == lpm_pkg::RUN && o_clk_src == `LPM_SRC_PLL;
      o_fast_int_en <= state_d == lpm_pkg::RUN && o_clk_src != `LPM_SRC_MS_OSC;
      o_fast_xtal_en <= state_d == lpm_pkg::RUN && o_clk_src == `LPM_SRC_FAST_XTAL;
      o_slow_osc_en <= 1'b1;
      o_reg_lp <= state_d == lpm_pkg::LP_RUN || state_d == lpm_pkg::LP_SLEEP
                  || state_d == lpm_pkg::STOP;
      o_retain <= state_d == lpm_pkg::STOP;
      o_mode <= 4'(state_d);
    end
  end

  assign o_wake_pulse = (state_q == lpm_pkg::WAKE) && wcnt_done;
  assign o_opt_load_start = (state_q == lpm_pkg::BOOT_WAIT) && i_supply_ok;
  assign o_boot_done = (state_q != lpm_pkg::BOOT_WAIT) && (state_q != lpm_pkg::BOOT_LOAD);

  // Strap is caught by the clock while waiting for supply, never under reset
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_por_thr_high <= 1'b0;
    else if (state_q == lpm_pkg::BOOT_WAIT)
      o_por_thr_high <= i_brownout_strap;
  end

  // Brownout disable is permanent until the next reset
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_brownout_en <= 1'b0;
      o_brownout_lvl <= `LPM_BROWNOUT_LVL_RST;
      o_vdd_min_low <= 1'b1;
    end
    else if (state_q == lpm_pkg::BOOT_WAIT)
    begin
      o_brownout_en <= i_brownout_strap;
      o_vdd_min_low <= !i_brownout_strap;
    end
    else if (state_q == lpm_pkg::BOOT_LOAD && i_opt_valid)
    begin
      o_brownout_en <= !i_opt_brownout_off;
      o_brownout_lvl <= i_opt_brownout_lvl;
      o_vdd_min_low <= i_opt_brownout_off;
    end
  end

  // Range 3 cannot run from anything but the multispeed oscillator
  assign range_ok = i_range_sel != 2'h0
                    && (i_range_sel != `LPM_RANGE3 || o_clk_src == `LPM_SRC_MS_OSC);
  assign src_ok = (o_vrange != `LPM_RANGE3 || i_src_sel == `LPM_SRC_MS_OSC)
                  && state_q == lpm_pkg::RUN;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_vrange <= `LPM_RANGE_RST;
      o_clk_src <= `LPM_SRC_RST;
      o_cfg_refused <= 1'b0;
    end
    else
    begin
      if (i_range_wr && range_ok)
        o_vrange <= i_range_sel;
      if (i_src_wr && src_ok && !(i_range_wr && i_range_sel == `LPM_RANGE3))
        o_clk_src <= i_src_sel;
      o_cfg_refused <= (i_range_wr && !range_ok) || (i_src_wr && !src_ok);
    end
  end

  always_comb
  begin
    case (o_vrange)
      `LPM_RANGE1: o_fmax_khz = `LPM_R1_MAX_KHZ;
      `LPM_RANGE3: o_fmax_khz = `LPM_R3_MAX_KHZ;
      default: o_fmax_khz = `LPM_R2_MAX_KHZ;
    endcase
    if (o_ms_osc_min)
      o_fmax_khz = `LPM_MS_MIN_KHZ;
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_stop_hit;
    state_q == lpm_pkg::STOP && stop_hit;
  endsequence
  sequence s_back_run;
    ##[1:WAKE_MAX] (state_q == lpm_pkg::RUN && o_cpu_clk_en);
  endsequence

  chk_range_multi_only: assert property (o_vrange == `LPM_RANGE3 |->
    o_clk_src == `LPM_SRC_MS_OSC && o_fmax_khz <= `LPM_R3_MAX_KHZ)
    else $error("range 3 without multispeed source");
  chk_sleep_clocks: assert property (state_q == lpm_pkg::SLEEP && wake_any |->
    !o_cpu_clk_en && o_periph_clk_en ##1 state_q == lpm_pkg::RUN && o_cpu_clk_en)
    else $error("sleep clocking or wake wrong");
  chk_lprun_setup: assert property (state_q == lpm_pkg::LP_RUN |->
    o_ms_osc_min && o_reg_lp && o_fmax_khz == `LPM_MS_MIN_KHZ && o_clk_src == `LPM_SRC_MS_OSC)
    else $error("low-power run setup wrong");
  chk_lpsleep_entry: assert property ($rose(state_q == lpm_pkg::LP_SLEEP) |->
    $past(state_q) == lpm_pkg::LP_RUN && o_reg_lp && !o_cpu_clk_en)
    else $error("low-power sleep entry wrong");
  chk_lpsleep_wake: assert property (state_q == lpm_pkg::LP_SLEEP && wake_any |=>
    state_q == lpm_pkg::RUN && !o_reg_lp && o_cpu_clk_en)
    else $error("low-power sleep wake wrong");
  chk_stop_gating: assert property (state_q == lpm_pkg::STOP |->
    !o_cpu_clk_en && !o_periph_clk_en && !o_pll_en && !o_ms_osc_en
    && !o_fast_int_en && !o_fast_xtal_en && o_reg_lp)
    else $error("stop did not gate clocks");
  chk_stop_retain: assert property (state_q == lpm_pkg::STOP |->
    o_slow_osc_en && o_retain && $stable(o_vrange))
    else $error("stop lost retention");
  chk_stop_exit: assert property (s_stop_hit |-> s_back_run)
    else $error("stop exit too slow");
  chk_wake_lines: assert property (state_q == lpm_pkg::STOP && |i_ext_lines |=>
    state_q == lpm_pkg::WAKE && o_wake_src[`LPM_WAKE_W-1 -: `LPM_EXT_LINES] != '0)
    else $error("external line did not wake");
  chk_opt_load: assert property (state_q == lpm_pkg::BOOT_WAIT && i_supply_ok |->
    o_opt_load_start && !o_boot_done ##1 state_q == lpm_pkg::BOOT_LOAD)
    else $error("option load not started");
  chk_brownout_off: assert property (state_q == lpm_pkg::BOOT_LOAD && i_opt_valid |=>
    o_brownout_en == !$past(i_opt_brownout_off) && o_vdd_min_low == $past(i_opt_brownout_off)
    && o_boot_done)
    else $error("brownout options not applied");
  chk_halt_gate: assert property ($fell(o_cpu_clk_en) |->
    $past(i_core_halted))
    else $error("clock gated before halt");
endmodule
`default_nettype wire

// ==== dv/lpm_core_model.sv ====
// Behavioural core: asks for low power, halts, resumes when its clock returns
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_go,
  input wire logic i_cpu_clk_en,
  output logic o_lp_req,
  output logic o_halted
);
  // Halt lags the request by a cycle, so gating before halt would show
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_lp_req <= 1'h0;
      o_halted <= 1'h0;
    end
    else if (i_go && !o_lp_req && !o_halted)
      o_lp_req <= 1'h1;
    else if (o_lp_req && !o_halted)
      o_halted <= 1'h1;
    else if (o_halted && !i_cpu_clk_en)
      o_lp_req <= 1'h0;
    else if (o_halted && !o_lp_req && i_cpu_clk_en)
      o_halted <= 1'h0;
  end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpm_params.svh"
module testbench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic so = 1'h0, strap = 1'h1, ov = 1'h0, boff = 1'h0, rw = 1'h0, sw = 1'h0;
  logic vref = 1'h1;
  logic [2:0] lv = 3'h0;
  logic lpr = 1'h0, irq = 1'h0, evt = 1'h0, deep = 1'h0, go = 1'h0;
  logic [1:0] rs = 2'h0, ss = 2'h0;
  logic [24:0] wk = 25'h0;
  wire ls, bd, pth, ben, vml, rf, wp, req, hlt;
  wire [2:0] bl;
  wire [1:0] vr, cs;
  wire [15:0] fm;
  wire [24:0] ws;
  wire [3:0] md;
  wire [9:0] fl;
  int fail_count = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  lpm_core_model lpm_core_model_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_go(go),
    .i_cpu_clk_en(fl[9]), .o_lp_req(req), .o_halted(hlt));
  lpm_ctrl lpm_ctrl_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_supply_ok(so),
    .i_brownout_strap(strap), .i_opt_valid(ov), .i_opt_brownout_lvl(lv),
    .i_opt_brownout_off(boff),
    .i_range_wr(rw), .i_range_sel(rs), .i_src_wr(sw), .i_src_sel(ss),
    .i_lprun_req(lpr), .i_lp_req(req), .i_deep(deep), .i_core_halted(hlt),
    .i_irq_any(irq), .i_event(evt), .i_ext_lines(wk[24:9]), .i_supply_det(wk[8]),
    .i_cmp1(wk[7]), .i_cmp2(wk[6]), .i_vref_on(vref), .i_rtc_alarm(wk[5:4]),
    .i_usb_wake(wk[3]), .i_rtc_tamper(wk[2]), .i_rtc_tstamp(wk[1]), .i_rtc_wake(wk[0]),
    .o_opt_load_start(ls), .o_boot_done(bd), .o_por_thr_high(pth), .o_brownout_en(ben),
    .o_brownout_lvl(bl), .o_vdd_min_low(vml), .o_vrange(vr), .o_clk_src(cs),
    .o_fmax_khz(fm), .o_cfg_refused(rf), .o_cpu_clk_en(fl[9]), .o_periph_clk_en(fl[8]),
    .o_pll_en(fl[7]), .o_ms_osc_en(fl[6]), .o_ms_osc_min(fl[5]), .o_fast_int_en(fl[4]),
    .o_fast_xtal_en(fl[3]), .o_slow_osc_en(fl[2]), .o_reg_lp(fl[1]), .o_retain(fl[0]),
    .o_wake_pulse(wp), .o_wake_src(ws), .o_mode(md));

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Every wait is bounded; a stuck mode ends the run as a mismatch
  task automatic wait_mode(input logic [3:0] m);
    int n;
    n = 0;
    // Step past the edge so the registered mode has settled before it is read
    #1;
    while (md !== m && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (md !== m)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic go_core(input logic [3:0] m);
    @(posedge clk) go <= 1'h1;
    @(posedge clk) go <= 1'h0;
    #1;
    check(md, m);
  endtask

  task automatic boot(input logic s, input logic off, input logic [2:0] l);
    @(posedge clk);
    rst <= 1'h1;
    strap <= s;
    boff <= off;
    lv <= l;
    so <= 1'h0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk) so <= 1'h1;
    #1;
    check(ls, 1'h1);
    wait_mode(4'h1);
    @(posedge clk) ov <= 1'h1;
    @(posedge clk) ov <= 1'h0;
    wait_mode(4'h2);
    check({bd, pth, ben, vml}, {1'h1, s, !off, off});
    check(bl, l);
  endtask

  initial
  begin
    logic [35:0] cf;
    logic [3:0] c;
    logic [1:0] er, es;
    int n;
    cf = 36'h487A2B621;
    er = 2'h2;
    es = 2'h0;
    boot(1'h0, 1'h1, 3'h2);
    boot(1'h1, 1'h0, 3'h5);
    check(bl, 3'h5);
    for (int i = 0; i < 9; i++)
    begin
      c = cf[4*i +: 4];
      @(posedge clk);
      rw <= !c[3];
      sw <= c[3];
      rs <= c[2:1];
      ss <= c[2:1];
      @(posedge clk);
      rw <= 1'h0;
      sw <= 1'h0;
      #1;
      check(rf, c[0]);
      if (!c[0] && c[3])
        es = c[2:1];
      else if (!c[0])
        er = c[2:1];
      check({vr, cs}, {er, es});
      check(fm, er == 2'h1 ? `LPM_R1_MAX_KHZ :
        er == 2'h2 ? `LPM_R2_MAX_KHZ : `LPM_R3_MAX_KHZ);
    end
    go_core(4'h2);
    wait_mode(4'h4);
    check(fl[9:8], 2'h1);
    @(posedge clk) irq <= 1'h1;
    wait_mode(4'h2);
    @(posedge clk) irq <= 1'h0;
    check(fl[9], 1'h1);
    @(posedge clk) lpr <= 1'h1;
    wait_mode(4'h3);
    check({fl[6:5], fl[1], fm}, {3'h7, `LPM_MS_MIN_KHZ});
    go_core(4'h3);
    wait_mode(4'h5);
    check({fl[9], fl[1]}, 2'h1);
    @(posedge clk) lpr <= 1'h0;
    @(posedge clk) evt <= 1'h1;
    wait_mode(4'h2);
    @(posedge clk) evt <= 1'h0;
    check({fl[9], fl[1]}, 2'h2);
    @(posedge clk) deep <= 1'h1;
    for (int k = 0; k < 25; k++)
    begin
      go_core(4'h2);
      wait_mode(4'h6);
      check(fl, 10'h007);
      // Comparator lines must stay silent while the reference is off
      if (k == 6 || k == 7)
      begin
        @(posedge clk) vref <= 1'h0;
        @(posedge clk) wk[k] <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        check(md, 4'h6);
      end
      @(posedge clk) vref <= 1'h1;
      wk[k] <= 1'h1;
      n = 0;
      while (wp !== 1'h1 && n < 1000)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      check(n <= `LPM_WAKE_CYC, 1'h1);
      check(ws, 25'h1 << k);
      @(posedge clk) wk <= 25'h0;
      wait_mode(4'h2);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
